// File: rtl/reg_decoder_defines.vh
// Constants for the multiplexed-bus register decoder
`ifndef REG_DECODER_DEFINES_VH
`define REG_DECODER_DEFINES_VH

// Register indices within one channel
`define IDX_CMD          4'h0
`define IDX_STAT1        4'h1
`define IDX_VECTOR       4'h2
`define IDX_RX_CTRL      4'h3
`define IDX_MODE4        4'h4
`define IDX_TX_CTRL5     4'h5
`define IDX_FRAME_LOW    4'h6
`define IDX_CTRL7        4'h7
`define IDX_RX_DATA      4'h8
`define IDX_MASTER       4'h9
`define IDX_MISC10       4'ha
`define IDX_CLK11        4'hb
`define IDX_BAUD_LOW     4'hc
`define IDX_BAUD_HIGH    4'hd
`define IDX_MISC14       4'he
`define IDX_EXT_CFG      4'hf

// Captured address fields
`define ADDR_IDX_MSB     4
`define ADDR_IDX_LSB     1
`define ADDR_CHAN_LEFT   5
`define ADDR_CHAN_RIGHT  0

// Alignment command in the command pointer register, low two bits
`define CMD_ALIGN_LSB    0
`define CMD_ALIGN_MSB    1
`define CMD_SHIFT_LEFT   2'h2
`define CMD_SHIFT_RIGHT  2'h3

// Field positions in configuration registers
`define EXT_CFG_PRIME_EN 0
`define EXT_CFG_FIFO_EN  2
`define PRIME_EXT_READ   6

// Reset values
`define RST_BYTE         8'h00
`define RST_ALIGN_RIGHT  1'b0

// Packed status byte positions in the channel status input
`define ST_RR0           3'h0
`define ST_RR1           3'h1
`define ST_RR3           3'h2
`define ST_RR6           3'h3
`define ST_RR7           3'h4
`define ST_RR8           3'h5
`define ST_RR10          3'h6
`define ST_BYTES         7

`endif

// File: rtl/muxed_bus_register_decoder.v
// Register decoder for a two-channel controller on a muxed address/data bus
`timescale 1ns/1ps
`default_nettype none
`include "reg_decoder_defines.vh"
// Bus cycle as seen from this block
//   Cycle 0: address strobe low, address on the shared lines.
//   Cycle 1: strobe high again; the address is latched at the edge that ends this cycle.
//   Cycle 2 on: write or read strobes use the latched address.
//   A strobe in the capture cycle itself still uses the old address.
//   Any number of accesses may follow one address phase.
//
// Limitations
//   The strobe is taken as a same-clock signal; a free-running host
//   on another clock needs its own synchroniser in front of this port.
//   The serial channels themselves live elsewhere; their status bytes
//   arrive packed on the two channel status inputs.
//   Writes to slots that no read path returns are kept anyway, but no
//   output port carries them, so the channel logic cannot pick them up.
//
module muxed_bus_register_decoder #(
  parameter DATA_W = 8
) (
  input  wire                      clk_i,
  input  wire                      sys_rst_i,
  input  wire                      addr_strobe_n_i,
  input  wire [DATA_W-1:0]         muxed_addr_data_bus_i,
  output reg  [DATA_W-1:0]         muxed_addr_data_bus_o,
  output reg                       muxed_addr_data_bus_oe_n_o,
  input  wire                      wr_strobe_i,
  input  wire                      rd_strobe_i,
  input  wire [8*`ST_BYTES-1:0]    chan_a_status_i,
  input  wire [8*`ST_BYTES-1:0]    chan_b_status_i,
  output reg                       shift_right_o,
  output reg  [DATA_W-1:0]         shared_vector_o,
  output reg  [DATA_W-1:0]         shared_master_ctrl_o
);

  // Per-channel write register files; index 2 and 9 slots stay unused
  reg  [DATA_W-1:0] wr_a_reg [0:15];
  reg  [DATA_W-1:0] wr_b_reg [0:15];
  reg  [DATA_W-1:0] ext_ctrl_prime_a_reg;
  reg  [DATA_W-1:0] ext_ctrl_prime_b_reg;
  reg  [DATA_W-1:0] addr_reg;
  reg               strobe_n_prev_reg;
  reg               align_right_reg;
  reg  [DATA_W-1:0] rd_data_next;
  wire              strobe_rise;
  wire              cur_chan_a;
  wire [3:0]        cur_idx;
  integer           k;

  // Channel select from the captured address; the other position is ignored
  function chan_sel;
    input [DATA_W-1:0] addr;
    input              right_mode;
    begin
      if (right_mode) begin
        chan_sel = addr[`ADDR_CHAN_RIGHT];
      end else begin
        chan_sel = addr[`ADDR_CHAN_LEFT];
      end
    end
  endfunction

  // Status byte picker from a packed channel status word
  function [DATA_W-1:0] status_byte;
    input [8*`ST_BYTES-1:0] st;
    input [2:0]             pos;
    begin
      status_byte = st[pos*8 +: 8];
    end
  endfunction

  // Address strobe edge; host logic shares our clock, so no synchroniser
  assign strobe_rise = addr_strobe_n_i & ~strobe_n_prev_reg;

  assign cur_chan_a = chan_sel(addr_reg, align_right_reg);
  assign cur_idx    = addr_reg[`ADDR_IDX_MSB:`ADDR_IDX_LSB];

  // Address capture
  // The previous strobe level resets high, the idle level of the pin,
  // so leaving reset never looks like a rising strobe.
  // Bits 7 and 6 are latched too but never decoded.
  always @(posedge clk_i) begin
    if (sys_rst_i) begin
      strobe_n_prev_reg <= 1'b1;
      addr_reg          <= `RST_BYTE;
    end else begin
      strobe_n_prev_reg <= addr_strobe_n_i;
      if (strobe_rise) begin
        addr_reg <= muxed_addr_data_bus_i;
      end
    end
  end

  // Alignment mode, held beside channel B command register
  // Only the two command codes move the mode, so software may write the
  // command register freely without knowing the current alignment.
  // A command byte written through channel A never touches the mode.
  // The new mode takes effect from the next cycle, and also re-decodes the address already latched.
  always @(posedge clk_i) begin
    if (sys_rst_i) begin
      align_right_reg <= `RST_ALIGN_RIGHT;
    end else if (wr_strobe_i && !cur_chan_a && cur_idx == `IDX_CMD) begin
      case (muxed_addr_data_bus_i[`CMD_ALIGN_MSB:`CMD_ALIGN_LSB])
        `CMD_SHIFT_LEFT:  align_right_reg <= 1'b0;
        `CMD_SHIFT_RIGHT: align_right_reg <= 1'b1;
        default:          align_right_reg <= align_right_reg;
      endcase
    end
  end

  // Write path: per-channel files, shared registers, prime register
  // Routing by index
  //   2: shared vector, whichever channel was addressed
  //   9: shared master control, whichever channel was addressed
  //   7: prime register while that channel's enable bit is set,
  //      otherwise the ordinary slot 7
  //   others: that channel's own slot
  // Slots 2 and 9 of the files are kept only to keep indexing simple;
  // the trade is two unused bytes per channel for a plain decode.
  always @(posedge clk_i) begin
    if (sys_rst_i) begin
      for (k = 0; k < 16; k = k + 1) begin
        wr_a_reg[k] <= `RST_BYTE;
        wr_b_reg[k] <= `RST_BYTE;
      end
      ext_ctrl_prime_a_reg <= `RST_BYTE;
      ext_ctrl_prime_b_reg <= `RST_BYTE;
      shared_vector_o      <= `RST_BYTE;
      shared_master_ctrl_o <= `RST_BYTE;
    end else if (wr_strobe_i) begin
      case (cur_idx)
        `IDX_VECTOR: shared_vector_o <= muxed_addr_data_bus_i;
        `IDX_MASTER: shared_master_ctrl_o <= muxed_addr_data_bus_i;
        `IDX_CTRL7: begin
          if (cur_chan_a) begin
            if (wr_a_reg[`IDX_EXT_CFG][`EXT_CFG_PRIME_EN]) begin
              ext_ctrl_prime_a_reg <= muxed_addr_data_bus_i;
            end else begin
              wr_a_reg[`IDX_CTRL7] <= muxed_addr_data_bus_i;
            end
          end else begin
            if (wr_b_reg[`IDX_EXT_CFG][`EXT_CFG_PRIME_EN]) begin
              ext_ctrl_prime_b_reg <= muxed_addr_data_bus_i;
            end else begin
              wr_b_reg[`IDX_CTRL7] <= muxed_addr_data_bus_i;
            end
          end
        end
        default: begin
          if (cur_chan_a) begin
            wr_a_reg[cur_idx] <= muxed_addr_data_bus_i;
          end else begin
            wr_b_reg[cur_idx] <= muxed_addr_data_bus_i;
          end
        end
      endcase
    end
  end

  // Read multiplexer with partial decoding and aliases
  // Read map per channel index (fifo = cfg bit 2, ext = prime bit 6)
  //    0  status 0
  //    1  status 1
  //    2  shared vector
  //    3  status 3
  //    4  ext ? written 4 : status 0
  //    5  ext ? written 5 : status 1
  //    6  fifo ? frame count low : shared vector
  //    7  fifo ? frame count high and fifo status : status 3
  //    8  receive data
  //    9  ext ? written 3 : written 13
  //   10  status 10
  //   11  ext ? written 10 : written 15
  //   12  written 12
  //   13  written 13
  //   14  ext ? prime register : written 14
  //   15  written 15
  // Extended read is taken on its own bit, whatever the fifo bit says.
  // No index falls through to an undefined byte.
  always @* begin : rd_mux
    reg [8*`ST_BYTES-1:0] st;
    reg [DATA_W-1:0]      w3;
    reg [DATA_W-1:0]      w4;
    reg [DATA_W-1:0]      w5;
    reg [DATA_W-1:0]      w10;
    reg [DATA_W-1:0]      w12;
    reg [DATA_W-1:0]      w13;
    reg [DATA_W-1:0]      w14;
    reg [DATA_W-1:0]      w15;
    reg [DATA_W-1:0]      prime;
    reg                   fifo_en;
    reg                   ext_rd;
    st      = cur_chan_a ? chan_a_status_i : chan_b_status_i;
    w3      = cur_chan_a ? wr_a_reg[`IDX_RX_CTRL] : wr_b_reg[`IDX_RX_CTRL];
    w4      = cur_chan_a ? wr_a_reg[`IDX_MODE4] : wr_b_reg[`IDX_MODE4];
    w5      = cur_chan_a ? wr_a_reg[`IDX_TX_CTRL5] : wr_b_reg[`IDX_TX_CTRL5];
    w10     = cur_chan_a ? wr_a_reg[`IDX_MISC10] : wr_b_reg[`IDX_MISC10];
    w12     = cur_chan_a ? wr_a_reg[`IDX_BAUD_LOW] : wr_b_reg[`IDX_BAUD_LOW];
    w13     = cur_chan_a ? wr_a_reg[`IDX_BAUD_HIGH]
                         : wr_b_reg[`IDX_BAUD_HIGH];
    w14     = cur_chan_a ? wr_a_reg[`IDX_MISC14] : wr_b_reg[`IDX_MISC14];
    w15     = cur_chan_a ? wr_a_reg[`IDX_EXT_CFG] : wr_b_reg[`IDX_EXT_CFG];
    prime   = cur_chan_a ? ext_ctrl_prime_a_reg : ext_ctrl_prime_b_reg;
    fifo_en = w15[`EXT_CFG_FIFO_EN];
    ext_rd  = prime[`PRIME_EXT_READ];
    case (cur_idx)
      `IDX_CMD:       rd_data_next = status_byte(st, `ST_RR0);
      `IDX_STAT1:     rd_data_next = status_byte(st, `ST_RR1);
      `IDX_VECTOR:    rd_data_next = shared_vector_o;
      `IDX_RX_CTRL:   rd_data_next = status_byte(st, `ST_RR3);
      `IDX_MODE4:     rd_data_next = ext_rd ? w4
                                     : status_byte(st, `ST_RR0);
      `IDX_TX_CTRL5:  rd_data_next = ext_rd ? w5
                                     : status_byte(st, `ST_RR1);
      `IDX_FRAME_LOW: rd_data_next = fifo_en ? status_byte(st, `ST_RR6)
                                     : shared_vector_o;
      `IDX_CTRL7:     rd_data_next = fifo_en ? status_byte(st, `ST_RR7)
                                     : status_byte(st, `ST_RR3);
      `IDX_RX_DATA:   rd_data_next = status_byte(st, `ST_RR8);
      `IDX_MASTER:    rd_data_next = ext_rd ? w3 : w13;
      `IDX_MISC10:    rd_data_next = status_byte(st, `ST_RR10);
      `IDX_CLK11:     rd_data_next = ext_rd ? w10 : w15;
      `IDX_BAUD_LOW:  rd_data_next = w12;
      `IDX_BAUD_HIGH: rd_data_next = w13;
      `IDX_MISC14:    rd_data_next = ext_rd ? prime : w14;
      default:        rd_data_next = w15;
    endcase
  end

  // Read answer: enable stands for the one cycle after the strobe, data until the next read
  // Data is latched only on a read, so the lines keep the last answer
  // while the host drives them; the enable alone says who owns them.
  always @(posedge clk_i) begin
    if (sys_rst_i) begin
      muxed_addr_data_bus_o      <= `RST_BYTE;
      muxed_addr_data_bus_oe_n_o <= 1'b1;
    end else begin
      muxed_addr_data_bus_oe_n_o <= ~rd_strobe_i;
      if (rd_strobe_i) begin
        muxed_addr_data_bus_o <= rd_data_next;
      end
    end
  end

  // Mode shown to the rest of the chip
  always @(posedge clk_i) begin
    if (sys_rst_i) begin
      shift_right_o <= `RST_ALIGN_RIGHT;
    end else begin
      shift_right_o <= align_right_reg;
    end
  end

endmodule // muxed_bus_register_decoder
`default_nettype wire

// File: tb/decoder_checker_asserts.sv
// Port-level assertions for the muxed-bus register decoder
`timescale 1ns/1ps
`default_nettype none
module decoder_checker #(parameter DATA_W = 8) (
  input wire logic              clk_i,
  input wire logic              sys_rst_i,
  input wire logic              addr_strobe_n_i,
  input wire logic [DATA_W-1:0] muxed_addr_data_bus_i,
  input wire logic [DATA_W-1:0] muxed_addr_data_bus_o,
  input wire logic              muxed_addr_data_bus_oe_n_o,
  input wire logic              wr_strobe_i,
  input wire logic              rd_strobe_i,
  input wire logic              shift_right_o,
  input wire logic [DATA_W-1:0] shared_vector_o,
  input wire logic [DATA_W-1:0] shared_master_ctrl_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);
  // Enable low exactly in the cycle after each read strobe
  property p_oe; muxed_addr_data_bus_oe_n_o == !$past(rd_strobe_i); endproperty
  a_oe: assert property (p_oe) else $error("oe timing");
  property p_hold; !$past(rd_strobe_i) |-> $stable(muxed_addr_data_bus_o);
  endproperty
  a_hold: assert property (p_hold) else $error("read data moved");
  property p_rst; $fell(sys_rst_i) |-> !shift_right_o; endproperty
  a_rst: assert property (p_rst) else $error("not left after reset");
  // Mode output lags the write edge by two samples
  property p_right; $rose(shift_right_o) |-> $past(wr_strobe_i, 2) &&
    $past(muxed_addr_data_bus_i[1:0], 2) == 2'h3; endproperty
  a_right: assert property (p_right) else $error("bad right");
  property p_left; $fell(shift_right_o) |-> $past(wr_strobe_i, 2) &&
    $past(muxed_addr_data_bus_i[1:0], 2) == 2'h2; endproperty
  a_left: assert property (p_left) else $error("bad left");
  property p_vec; $changed(shared_vector_o) |-> $past(wr_strobe_i) &&
    shared_vector_o == $past(muxed_addr_data_bus_i); endproperty
  a_vec: assert property (p_vec) else $error("vector write");
  property p_mst; $changed(shared_master_ctrl_o) |-> $past(wr_strobe_i) &&
    shared_master_ctrl_o == $past(muxed_addr_data_bus_i); endproperty
  a_mst: assert property (p_mst) else $error("master write");
  property p_idx2; $rose(addr_strobe_n_i) && muxed_addr_data_bus_i[4:1]
    == 4'h2 ##1 rd_strobe_i |=> muxed_addr_data_bus_o == shared_vector_o;
  endproperty
  a_idx2: assert property (p_idx2) else $error("index 2 read");
endmodule // decoder_checker
bind muxed_bus_register_decoder decoder_checker #(.DATA_W(DATA_W)) chk_i (
  .clk_i, .sys_rst_i, .addr_strobe_n_i, .muxed_addr_data_bus_i,
  .muxed_addr_data_bus_o, .muxed_addr_data_bus_oe_n_o, .wr_strobe_i,
  .rd_strobe_i, .shift_right_o, .shared_vector_o, .shared_master_ctrl_o);
`default_nettype wire

// File: tb/host_bus_model.sv
// Host processor model on the multiplexed bus
`timescale 1ns/1ps
`default_nettype none
module host_bus_model (
  input  wire logic       clk_i,
  output var  logic       addr_strobe_n_o,
  output var  logic [7:0] bus_o,
  output var  logic       wr_o,
  output var  logic       rd_o
);
  initial begin
    addr_strobe_n_o = 1'b1;
    bus_o = 8'h5a;
    wr_o = 1'b0;
    rd_o = 1'b0;
  end
  task automatic adr(input logic [7:0] a);
    @(posedge clk_i);
    addr_strobe_n_o <= 1'b0;
    bus_o <= a;
    @(posedge clk_i);
    addr_strobe_n_o <= 1'b1;
  endtask
  // Released bus shows inverted data, never a stale copy
  task automatic wr(input logic [7:0] d);
    @(posedge clk_i);
    wr_o <= 1'b1;
    bus_o <= d;
    @(posedge clk_i);
    wr_o <= 1'b0;
    bus_o <= ~d;
  endtask
  task automatic rd;
    @(posedge clk_i);
    rd_o <= 1'b1;
    bus_o <= ~bus_o;
    @(posedge clk_i);
    rd_o <= 1'b0;
  endtask
endmodule // host_bus_model
`default_nettype wire

// File: tb/tb.sv
// Self-checking bench for the muxed-bus register decoder
`timescale 1ns/1ps
`default_nettype none
`include "reg_decoder_defines.vh"
module tb;
  logic        clk_i = 1'b0;
  logic        sys_rst_i = 1'b1;
  logic        rm = 1'b0;
  logic [55:0] sa, sb;
  logic [7:0]  wv [2][16];
  logic [7:0]  exp_q [$];
  int          errors = 0;
  int          num_checks = 0;
  wire logic       as_n, wr, rd, oe_n, sr;
  wire logic [7:0] hbus, dout, vec, mst;
  // Device owns the bus only while its enable is low
  wire logic [7:0] bus = oe_n ? hbus : dout;
  always #10 clk_i = ~clk_i;
  host_bus_model host (.clk_i(clk_i), .addr_strobe_n_o(as_n), .bus_o(hbus),
    .wr_o(wr), .rd_o(rd));
  muxed_bus_register_decoder dut (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
    .addr_strobe_n_i(as_n), .muxed_addr_data_bus_i(bus),
    .muxed_addr_data_bus_o(dout), .muxed_addr_data_bus_oe_n_o(oe_n),
    .wr_strobe_i(wr), .rd_strobe_i(rd), .chan_a_status_i(sa),
    .chan_b_status_i(sb), .shift_right_o(sr), .shared_vector_o(vec),
    .shared_master_ctrl_o(mst));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("Error %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic conclude;
    $display("checks %0d mismatches %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // junk in top bits and unused channel slot
  function automatic logic [7:0] ad(input logic c, input logic [3:0] i);
    logic [2:0] r;
    r = 3'($urandom);
    return rm ? {r, i, c} : {r[1:0], c, i, r[2]};
  endfunction
  function automatic logic [7:0] ex(input logic c, input logic [3:0] i);
    logic [55:0] s;
    logic        f, e;
    s = c ? sa : sb;
    f = wv[c][15][`EXT_CFG_FIFO_EN];
    e = wv[c][7][`PRIME_EXT_READ];
    case (i)
      4'h0, 4'h4: ex = e && i[2] ? wv[c][4] : s[8*`ST_RR0+:8];
      4'h1, 4'h5: ex = e && i[2] ? wv[c][5] : s[8*`ST_RR1+:8];
      4'h3: ex = s[8*`ST_RR3+:8];
      4'h2, 4'h6: ex = f && i[2] ? s[8*`ST_RR6+:8] : wv[0][2];
      4'h7: ex = f ? s[8*`ST_RR7+:8] : s[8*`ST_RR3+:8];
      4'h8: ex = s[8*`ST_RR8+:8];
      4'h9: ex = e ? wv[c][3] : wv[c][13];
      4'ha: ex = s[8*`ST_RR10+:8];
      4'hb: ex = e ? wv[c][10] : wv[c][15];
      4'he: ex = e ? wv[c][7] : wv[c][14];
      default: ex = wv[c][i];
    endcase
  endfunction
  // Write and note its effect; slot 7 holds the prime register
  task automatic w(input logic c, input logic [3:0] i, input logic [7:0] d);
    host.adr(ad(c, i));
    host.wr(d);
    if (i == 4'h2 || i == 4'h9) begin
      wv[0][i] = d;
      wv[1][i] = d;
    end else if (i != 4'h7 || wv[c][15][`EXT_CFG_PRIME_EN])
      wv[c][i] = d;
    if (i == 4'h0 && !c && d[1])
      rm = d[0];
  endtask
  task automatic rall;
    for (int c = 0; c < 2; c++)
      for (int i = 0; i < 16; i++) begin
        host.adr(ad(c[0], i[3:0]));
        exp_q.push_back(ex(c[0], i[3:0]));
        host.rd();
      end
  endtask
  // Oldest note is matched against each read answer
  always @(posedge clk_i)
    if (oe_n === 1'b0)
      chk(dout, exp_q.pop_front());
  initial begin
    void'($urandom(71));
    sa = 56'({$urandom, $urandom});
    sb = 56'({$urandom, $urandom});
    wv = '{default: 8'h00};
    repeat (5) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    @(negedge clk_i);
    chk({7'h00, sr}, 8'h00);
    rall();
    $display("test reset done");
    for (int c = 0; c < 2; c++)
      for (int i = 1; i < 15; i++)
        w(c[0], i[3:0], 8'($urandom));
    @(negedge clk_i);
    chk(vec, wv[0][2]);
    chk(mst, wv[1][9]);
    rall();
    w(1'b1, 4'hf, 8'h05);
    w(1'b1, 4'h7, 8'h40);
    w(1'b0, 4'h7, 8'h40);
    rall();
    w(1'b0, 4'hf, 8'h04);
    rall();
    $display("test alias done");
    // Mode output shows the new mode one edge after the write edge
    w(1'b1, 4'h0, 8'h03);
    repeat (2) @(negedge clk_i);
    chk({7'h00, sr}, 8'h00);
    w(1'b0, 4'h0, 8'h03);
    repeat (2) @(negedge clk_i);
    chk({7'h00, sr}, 8'h01);
    w(1'b0, 4'hc, 8'h3c);
    w(1'b1, 4'hc, 8'h3c);
    rall();
    w(1'b0, 4'h0, 8'h02);
    rall();
    $display("test mode done");
    sys_rst_i <= 1'b1;
    repeat (5) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    wv = '{default: 8'h00};
    rm = 1'b0;
    @(negedge clk_i);
    chk({7'h00, sr}, 8'h00);
    chk(vec, 8'h00);
    rall();
    repeat (4) @(posedge clk_i);
    chk(8'(exp_q.size()), 8'h00);
    $display("test rerun done");
    conclude();
  end
endmodule // tb
`default_nettype wire
